// [hdl/ufit_consts.svh]
/*
  constants of the frame interval timer: register offsets, field positions,
  reset values and bit-time rate figures.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef UFIT_CONSTS_SVH
`define UFIT_CONSTS_SVH

// register byte offsets inside the host controller window
`define UFIT_OFS_INTERVAL  8'h34
`define UFIT_OFS_REMAIN    8'h38
`define UFIT_ADDR_W        8

// interval register fields
`define UFIT_TOGGLE_BIT    31
`define UFIT_BUDGET_HI     30
`define UFIT_BUDGET_LO     16
`define UFIT_IVAL_HI       13
`define UFIT_IVAL_LO       0

// widths of the timing fields
`define UFIT_IVAL_W        14
`define UFIT_BUDGET_W      15

// reset values: nominal interval field is 11,999, a frame of 12,000 bit times
`define UFIT_IVAL_RST      14'h2EDF
`define UFIT_BUDGET_RST    15'h0000
`define UFIT_LEFT_RST      14'h0000

// core clock and full-speed bit rate, in hertz
`define UFIT_CLK_HZ        250000000
`define UFIT_BIT_HZ        12000000

`endif

// [hdl/ufit_pkg.sv]
/*
  types shared by the frame interval timer modules.
  assumes ufit_consts.svh is on the include path.
*/
`include "ufit_consts.svh"

package ufit_pkg;

  // register selected by the current access
  typedef enum logic [1:0] {
    UFIT_SEL_NONE     = 2'b00,
    UFIT_SEL_INTERVAL = 2'b01,
    UFIT_SEL_REMAIN   = 2'b10
  } ufit_sel_t;

  // interval field value
  typedef logic [`UFIT_IVAL_W-1:0]   ufit_ival_t;
  // largest packet budget value
  typedef logic [`UFIT_BUDGET_W-1:0] ufit_budget_t;

endpackage : ufit_pkg

// [hdl/ufit_bit_tick.sv]
/*
  bit-time strobe generator: a phase accumulator that yields, on average,
  BIT_HZ one-cycle pulses per second from a CLK_HZ clock.
  assumes BIT_HZ is at most CLK_HZ and both fit in 31 bits.
*/
`include "ufit_consts.svh"

module ufit_bit_tick #(
  parameter int unsigned CLK_HZ = `UFIT_CLK_HZ,
  parameter int unsigned BIT_HZ = `UFIT_BIT_HZ
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // one-cycle strobe per bit time
  output logic      o_tick
);

  localparam logic [31:0] STEP = 32'(BIT_HZ);  // phase added each cycle
  localparam logic [31:0] WRAP = 32'(CLK_HZ);  // phase of one full bit time

  logic [31:0] acc_r;    // current phase
  logic [31:0] sum;      // phase after this cycle's step
  logic        wrap;     // phase passes a bit-time boundary
  logic        tick_r;   // registered strobe

  assign sum    = acc_r + STEP;
  assign wrap   = (sum >= WRAP);
  assign o_tick = tick_r;

  // advance the phase, fold back on wrap
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= wrap ? (sum - WRAP) : sum;
      tick_r <= wrap;
    end
  end

endmodule : ufit_bit_tick

// [hdl/ufit_top.sv]
/*
  frame interval timer of a full/low-speed host controller: interval and
  remaining-time registers, remaining-time down counter, largest packet
  budget counter and start-of-frame strobe.
  assumes the register port and the running-state level come from logic on
  the same clock, so none of them is synchronised here.
*/
// Functional notes
// - budget field loads budget counter each frame
// - budget counter counts bits still transferable
// - interval field sets start-of-frame spacing
// - reset gives interval 11,999, others zero
// - remaining counter decrements once per bit time
// - zero reloads counter from interval next bit
// - zero copies interval toggle to remaining toggle
// - entering running state reloads counter from interval
`include "ufit_consts.svh"

module ufit_top #(
  parameter int unsigned CLK_HZ = `UFIT_CLK_HZ,
  parameter int unsigned BIT_HZ = `UFIT_BIT_HZ
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  // register port
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [31:0] I_REG_WDATA,
  output logic      [31:0] O_REG_RDATA,
  // controller state
  input  wire logic        I_RUNNING,
  // frame timing outputs
  output logic             O_SOF_PULSE,
  output logic             O_BIT_TICK,
  output logic      [13:0] O_FRAME_LEFT,
  output logic      [14:0] O_BUDGET_LEFT
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  ufit_pkg::ufit_ival_t   frame_interval_r;    // interval field
  ufit_pkg::ufit_budget_t budget_field_r;      // largest packet budget field
  logic                   interval_toggle_r;   // toggle written by software
  ufit_pkg::ufit_ival_t   frame_time_left_r;   // remaining-time counter
  logic                   remaining_toggle_r;  // toggle copied at frame end
  ufit_pkg::ufit_budget_t budget_cnt_r;        // largest packet budget counter
  logic                   running_r;           // running state, last cycle
  logic                   sof_r;               // start-of-frame strobe
  logic [31:0]            rdata_r;             // read data holding register
  logic                   bit_tick;            // one strobe per bit time
  ufit_pkg::ufit_sel_t    sel;                 // decoded register
  logic                   wr_interval;         // write to interval register
  logic                   wr_remain;           // write to remaining register
  logic                   run_start;           // entry into running state
  logic                   frame_end;           // counter at zero on a bit time
  logic                   frame_step;          // counter decrements this bit
  logic [31:0]            interval_word;       // interval register read view
  logic [31:0]            remain_word;         // remaining register read view
  logic [31:0]            rdata_nxt;           // selected read data

  ////////////////////////////////////////////////////////////////////////////
  // bit-time strobe

  ufit_bit_tick #(
    .CLK_HZ (CLK_HZ),
    .BIT_HZ (BIT_HZ)
  ) u_tick (
    .i_clk    (I_CLK),
    .i_arst_n (I_ARST_N),
    .o_tick   (bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // address decode, unmapped offsets select nothing
  assign sel = (I_REG_ADDR == `UFIT_OFS_INTERVAL) ? ufit_pkg::UFIT_SEL_INTERVAL :
               (I_REG_ADDR == `UFIT_OFS_REMAIN)   ? ufit_pkg::UFIT_SEL_REMAIN   :
                                                    ufit_pkg::UFIT_SEL_NONE;
  assign wr_interval = I_REG_WR && (sel == ufit_pkg::UFIT_SEL_INTERVAL);
  assign wr_remain   = I_REG_WR && (sel == ufit_pkg::UFIT_SEL_REMAIN);

  // running-state entry, highest priority on the counter
  assign run_start  = I_RUNNING && !running_r;
  // counting only while running and not overridden this cycle
  assign frame_end  = bit_tick && running_r && !run_start && !wr_remain &&
                      (frame_time_left_r == `UFIT_LEFT_RST);
  assign frame_step = bit_tick && running_r && !run_start && !wr_remain &&
                      (frame_time_left_r != `UFIT_LEFT_RST);

  // read views, reserved bits as zero
  assign interval_word = {interval_toggle_r, budget_field_r, 2'b00, frame_interval_r};
  assign remain_word   = {remaining_toggle_r, 17'h00000, frame_time_left_r};
  assign rdata_nxt     = (sel == ufit_pkg::UFIT_SEL_INTERVAL) ? interval_word :
                         (sel == ufit_pkg::UFIT_SEL_REMAIN)   ? remain_word   :
                                                                32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // interval register

  // software writes; reserved bits 15..14 are not stored
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      frame_interval_r  <= `UFIT_IVAL_RST;
      budget_field_r    <= `UFIT_BUDGET_RST;
      interval_toggle_r <= 1'b0;
    end else if (wr_interval) begin
      frame_interval_r  <= I_REG_WDATA[`UFIT_IVAL_HI:`UFIT_IVAL_LO];
      budget_field_r    <= I_REG_WDATA[`UFIT_BUDGET_HI:`UFIT_BUDGET_LO];
      interval_toggle_r <= I_REG_WDATA[`UFIT_TOGGLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remaining-time counter and toggle

  // priority: running entry, software write, frame end, decrement
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      frame_time_left_r  <= `UFIT_LEFT_RST;
      remaining_toggle_r <= 1'b0;
    end else if (run_start) begin
      frame_time_left_r  <= frame_interval_r;
    end else if (wr_remain) begin
      frame_time_left_r  <= I_REG_WDATA[`UFIT_IVAL_HI:`UFIT_IVAL_LO];
      remaining_toggle_r <= I_REG_WDATA[`UFIT_TOGGLE_BIT];
    end else if (frame_end) begin
      frame_time_left_r  <= frame_interval_r;
      remaining_toggle_r <= interval_toggle_r;
    end else if (frame_step) begin
      frame_time_left_r  <= frame_time_left_r - 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // largest packet budget counter, frame strobe, running edge

  // budget reloads at frame start, then drains one bit per bit time
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      budget_cnt_r <= `UFIT_BUDGET_RST;
      sof_r        <= 1'b0;
      running_r    <= 1'b0;
    end else begin
      running_r <= I_RUNNING;
      sof_r     <= frame_end;
      if (frame_end) begin
        budget_cnt_r <= budget_field_r;
      end else if (bit_tick && budget_cnt_r != 15'h0000) begin
        budget_cnt_r <= budget_cnt_r - 15'h0001;
      end
    end
  end

  // read data captured on a read strobe
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_r <= 32'h0;
    end else if (I_REG_RD) begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs
  assign O_REG_RDATA   = rdata_r;
  assign O_SOF_PULSE   = sof_r;
  assign O_BIT_TICK    = bit_tick;
  assign O_FRAME_LEFT  = frame_time_left_r;
  assign O_BUDGET_LEFT = budget_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic seen_clk_r;  // low only in the first cycle after reset release
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      seen_clk_r <= 1'b0;
    end else begin
      seen_clk_r <= 1'b1;
    end
  end

  // counter at zero on a bit time with nothing overriding it
  sequence s_frame_end;
    bit_tick && running_r && !run_start && !wr_remain &&
    (frame_time_left_r == 14'h0000);
  endsequence

  // reload followed by a strobe and the interval in the counter
  sequence s_new_frame;
    O_SOF_PULSE && (frame_time_left_r == $past(frame_interval_r));
  endsequence

  chk_reset_interval: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !seen_clk_r |-> (frame_interval_r == 14'h2EDF) && (budget_field_r == 15'h0000))
    else $error("interval not at nominal value after reset");

  chk_frame_reload: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_frame_end |=> s_new_frame)
    else $error("counter not reloaded from interval at zero");

  chk_toggle_copy: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    s_frame_end |=> (remaining_toggle_r == $past(interval_toggle_r)))
    else $error("remaining toggle not copied at frame end");

  chk_count_down: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (bit_tick && running_r && !run_start && !wr_remain && frame_time_left_r != 14'h0000)
    |=> (frame_time_left_r == $past(frame_time_left_r) - 14'h0001) && !O_SOF_PULSE)
    else $error("counter did not step down by one");

  chk_hold_between: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!bit_tick && !run_start && !wr_remain) |=> $stable(frame_time_left_r))
    else $error("counter moved without a bit time");

  chk_run_entry: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(I_RUNNING) |=> (frame_time_left_r == $past(frame_interval_r)) && !O_SOF_PULSE)
    else $error("counter not reloaded on running entry");

  chk_budget_load: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_SOF_PULSE |-> (budget_cnt_r == $past(budget_field_r)))
    else $error("budget counter not loaded at frame start");

  chk_budget_drain: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (bit_tick && !frame_end && budget_cnt_r != 15'h0000)
    |=> (budget_cnt_r == $past(budget_cnt_r) - 15'h0001))
    else $error("budget counter did not drain one bit");

  chk_interval_write: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    wr_interval |=> (frame_interval_r == $past(I_REG_WDATA[13:0])) &&
                    (interval_toggle_r == $past(I_REG_WDATA[31])))
    else $error("interval write not stored");

  chk_sof_cause: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_SOF_PULSE |-> $past(bit_tick) && ($past(frame_time_left_r) == 14'h0000))
    else $error("frame strobe without counter reaching zero");

endmodule : ufit_top

// [verif/ufit_top_bench.sv]
/*
  self-checking bench of the frame interval timer: register port tasks,
  reset values, frame spacing, toggle copy, reloads and a mid-run reset.
  assumes a tick on every clock (BIT_HZ equal to CLK_HZ) for short frames.
*/
`include "ufit_consts.svh"

module ufit_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // design signals
  logic        clk;          // core clock
  logic        arst_n;       // reset, active low
  logic [7:0]  reg_addr;     // register offset
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [31:0] reg_wdata;    // write data
  logic [31:0] reg_rdata;    // read data
  logic        running;      // running state level
  logic        sof_pulse;    // start-of-frame strobe
  logic        bit_tick;     // bit-time strobe
  logic [13:0] frame_left;   // remaining-time counter
  logic [14:0] budget_left;  // largest packet budget counter
  // bench bookkeeping
  int          bad_count;    // mismatches seen
  int          check_count;  // comparisons made
  int          gap;          // clocks between strobes
  logic [31:0] rd_val;       // last value read
  logic [31:0] rst_val;      // value read after reset

  // timer under test, one bit time per clock
  ufit_top #(.CLK_HZ(250000000), .BIT_HZ(250000000)) dut (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_REG_ADDR(reg_addr), .I_REG_WR(reg_wr),
    .I_REG_RD(reg_rd), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata),
    .I_RUNNING(running), .O_SOF_PULSE(sof_pulse), .O_BIT_TICK(bit_tick),
    .O_FRAME_LEFT(frame_left), .O_BUDGET_LEFT(budget_left)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare, count and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // one-cycle write strobe, then one idle edge so back-to-back calls never
  // lower and raise the strobe in the same time step
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_write

  // one-cycle read strobe, data registered by the read edge
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
    @(posedge clk);
    #1;
  endtask : reg_read

  // clocks up to the next start-of-frame, bounded
  task automatic wait_sof(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (sof_pulse !== 1'b1 && n < 100);
    if (n >= 100) check(32'h0, 32'h1);
  endtask : wait_sof

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #20000;
    bad_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
    running = 1'b0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    // reset values, unmapped read
    reg_read(8'h34, rd_val); check(rd_val, 32'h00002EDF);
    reg_read(8'h38, rd_val); check(rd_val, 32'h00000000);
    reg_read(8'h3C, rd_val); check(rd_val, 32'h00000000);
    check({17'h0, frame_left}, 32'h0);
    check({31'h0, bit_tick}, 32'h1);
    // toggle set, budget 16, interval 5
    reg_write(8'h34, 32'h80100005);
    reg_write(8'h3C, 32'hFFFFFFFF);
    reg_read(8'h34, rd_val); check(rd_val, 32'h80100005);
    // idle: counter stands
    check({17'h0, frame_left}, 32'h0);
    // running entry reloads from interval
    running = 1'b1;
    @(posedge clk);
    #1 check({17'h0, frame_left}, 32'h5);
    @(posedge clk);
    #1 check({17'h0, frame_left}, 32'h4);
    // zero reload starts the frame
    wait_sof(gap);
    check({17'h0, frame_left}, 32'h5);
    check({17'h0, budget_left}, 32'h10);
    reg_read(8'h38, rd_val); check({31'h0, rd_val[31]}, 32'h1);
    // two bit times drained during the read and its idle edge
    check({17'h0, budget_left}, 32'hE);
    // full frame measured strobe to strobe: interval plus one
    wait_sof(gap);
    wait_sof(gap); check(gap, 32'd6);
    // trim interval mid-frame, toggle back to 0
    reg_write(8'h34, 32'h00080003);
    wait_sof(gap); check({17'h0, frame_left}, 32'h3);
    check({17'h0, budget_left}, 32'h8);
    wait_sof(gap); check(gap, 32'd4);
    reg_read(8'h38, rd_val); check({31'h0, rd_val[31]}, 32'h0);
    // direct load of remaining counter, one bit time later it has stepped
    reg_write(8'h38, 32'h00000002);
    check({17'h0, frame_left}, 32'h1);
    // leaving running: one last step to zero, then the counter holds
    running = 1'b0;
    repeat (2) @(posedge clk);
    #1 check({17'h0, frame_left}, 32'h0);
    repeat (3) @(posedge clk);
    #1 check({17'h0, frame_left}, 32'h0);
    // mid-run reset, save and restore interval
    reg_read(8'h34, rd_val);
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    reg_read(8'h34, rst_val); check(rst_val, 32'h00002EDF);
    check({17'h0, budget_left}, 32'h0);
    reg_write(8'h34, rd_val);
    reg_read(8'h34, rst_val); check(rst_val, 32'h00080003);
    final_report();
  end

endmodule : ufit_top_bench
